// file: shared/scs_pkg.sv
// Constants, types and command decoding for the status and configuration select block
`default_nettype none
package scs_pkg;
	localparam int STORE_WORDS = 64;
	localparam logic [5:0] ADR_IF_SETUP = 6'h02;
	localparam logic [5:0] ADR_CFG_FIRST = 6'h03;
	localparam logic [5:0] ADR_CFG_SECOND = 6'h04;
	localparam logic [5:0] ADR_THR_A = 6'h13;
	localparam logic [5:0] ADR_THR_B = 6'h14;
	localparam logic [5:0] ADR_THR_C = 6'h15;
	localparam logic [5:0] ADR_SIGNATURE = 6'h39;
	localparam logic [5:0] CHK_LAST = ADR_SIGNATURE - 6'h01;
	localparam logic [5:0] CHK_FIRST = 6'h00;
	localparam logic [15:0] STORE_RESET = 16'h0000;
	// Arbitrary seed so an empty store fails the integrity check
	localparam logic [15:0] SIG_SEED = 16'h5A5A;
	localparam int IF_TYPE_BIT = 0;
	localparam int I2C_ADR_LSB = 1;
	localparam int I2C_ADR_MSB = 7;
	localparam int ST_SAT = 0;
	localparam int ST_CFG = 1;
	localparam int ST_MEMERR = 2;
	localparam int ST_CMD = 3;
	localparam int ST_TEST = 4;
	localparam int ST_BUSY = 5;
	localparam int ST_POWER = 6;
	localparam int ST_SPARE = 7;
	localparam logic [7:0] CMD_CFG_FIRST = 8'hB0;
	localparam logic [7:0] CMD_CFG_SECOND = 8'hB1;
	localparam logic [7:0] CMD_HALT_REPEAT = 8'hBF;
	localparam logic [7:0] CMD_CYCLIC = 8'hAB;
	localparam logic [7:0] CMD_MEASURE = 8'hAA;
	localparam logic [7:0] CMD_START_CM = 8'hA9;
	localparam logic [7:0] CMD_START_NM = 8'hA8;
	localparam logic [7:0] CMD_SPI_READ = 8'hF0;
	localparam logic [1:0] WR_BYTES = 2'h3;
	typedef enum logic [1:0] {
		SCS_CHECK = 2'b00,
		SCS_IDLE = 2'b01,
		SCS_MEAS = 2'b11,
		SCS_CYCLIC = 2'b10
	} scs_state_t;
	typedef enum logic [1:0] {
		SCS_I2C_IDLE = 2'b00,
		SCS_I2C_ADDR = 2'b01,
		SCS_I2C_WRITE = 2'b11,
		SCS_I2C_READ = 2'b10
	} scs_i2c_t;
	// Raw measurements A0..A7 and full measurement AA
	function automatic logic is_measure(input logic [7:0] c);
		is_measure = (c[7:3] == 5'h14) || (c == CMD_MEASURE);
	endfunction : is_measure
	function automatic logic is_store_rd(input logic [7:0] c);
		is_store_rd = (c[7:6] == 2'b00);
	endfunction : is_store_rd
	function automatic logic is_store_wr(input logic [7:0] c);
		is_store_wr = (c[7:6] == 2'b01);
	endfunction : is_store_wr
endpackage : scs_pkg
`default_nettype wire

// file: core/scs_i2c.sv
// I2C slave byte engine with address match
`timescale 1ns/10ps
`default_nettype none
module scs_i2c import scs_pkg::*; (
	input wire logic clock_in, // System clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic enable_in, // I2C selected
	input wire logic [6:0] addr_in, // Programmed slave address
	input wire logic [7:0] tx_byte_in, // Next byte to send
	input wire logic scl_in, // Bus clock level
	input wire logic sda_in, // Bus data level
	output logic sda_out, // Data drive value, always low
	output logic sda_oe_out, // Pull data low
	output logic frame_start_out, // Address matched pulse
	output logic frame_end_out, // Stop or repeated start pulse
	output logic rx_valid_out, // Byte written pulse
	output logic [7:0] rx_byte_out, // Byte written
	output logic tx_req_out // Need next read byte pulse
);
	scs_i2c_t st_r;
	logic scl_q, sda_q, more_r, inframe_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic start, stop, rise, fall;
	assign start = scl_in & scl_q & sda_q & ~sda_in;
	assign stop = scl_in & scl_q & ~sda_q & sda_in;
	assign rise = scl_in & ~scl_q;
	assign fall = ~scl_in & scl_q;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= SCS_I2C_IDLE;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
			frame_start_out <= 1'b0;
			frame_end_out <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_byte_out <= 8'h00;
			tx_req_out <= 1'b0;
			more_r <= 1'b0;
			inframe_r <= 1'b0;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
		end else begin
			frame_start_out <= 1'b0;
			frame_end_out <= 1'b0;
			rx_valid_out <= 1'b0;
			tx_req_out <= 1'b0;
			if (!enable_in) begin
				st_r <= SCS_I2C_IDLE;
				sda_oe_out <= 1'b0;
				inframe_r <= 1'b0;
			end else if (start || stop) begin
				frame_end_out <= inframe_r;
				inframe_r <= 1'b0;
				sda_oe_out <= 1'b0;
				bit_r <= 4'h0;
				st_r <= start ? SCS_I2C_ADDR : SCS_I2C_IDLE;
			end else if (st_r != SCS_I2C_IDLE && rise) begin
				if (bit_r == 4'h8) begin
					more_r <= ~sda_in;
					// Own address ack is no request; that byte came with frame start
					tx_req_out <= (st_r == SCS_I2C_READ) && !sda_in && !sda_oe_out;
				end else if (st_r != SCS_I2C_READ) begin
					sh_r <= {sh_r[6:0], sda_in};
				end
				bit_r <= bit_r + 4'h1;
			end else if (st_r != SCS_I2C_IDLE && fall) begin
				if (bit_r == 4'h8) begin
					unique case (st_r)
						SCS_I2C_ADDR: begin
							if (sh_r[7:1] == addr_in) begin
								sda_oe_out <= 1'b1;
								frame_start_out <= 1'b1;
								inframe_r <= 1'b1;
								more_r <= 1'b1;
								tx_req_out <= sh_r[0];
								st_r <= sh_r[0] ? SCS_I2C_READ : SCS_I2C_WRITE;
							end else begin
								st_r <= SCS_I2C_IDLE;
							end
						end
						SCS_I2C_WRITE: begin
							sda_oe_out <= 1'b1;
							rx_valid_out <= 1'b1;
							rx_byte_out <= sh_r;
						end
						SCS_I2C_READ: sda_oe_out <= 1'b0;
						SCS_I2C_IDLE: sda_oe_out <= 1'b0;
					endcase
				end else if (bit_r == 4'h9) begin
					bit_r <= 4'h0;
					if (st_r == SCS_I2C_READ && more_r) begin
						sh_r <= tx_byte_in;
						sda_oe_out <= ~tx_byte_in[7];
					end else begin
						// Write ack done or master refused more data; a refused read then waits quietly for stop
						sda_oe_out <= 1'b0;
						if (st_r == SCS_I2C_READ)
							st_r <= SCS_I2C_IDLE;
					end
				end else if (st_r == SCS_I2C_READ) begin
					sda_oe_out <= ~sh_r[6];
					sh_r <= {sh_r[6:0], 1'b0};
				end
			end
		end
	end
endmodule : scs_i2c
`default_nettype wire

// file: core/scs_spi.sv
// SPI mode 0 slave byte engine
`timescale 1ns/10ps
`default_nettype none
module scs_spi import scs_pkg::*; (
	input wire logic clock_in, // System clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic enable_in, // SPI selected
	input wire logic [7:0] tx_byte_in, // Next byte to send
	input wire logic cs_n_in, // Chip select, active low
	input wire logic sclk_in, // Serial clock
	input wire logic mosi_in, // Serial data in
	output logic miso_out, // Serial data out
	output logic miso_oe_out, // Drive data out
	output logic frame_start_out, // Select fell pulse
	output logic frame_end_out, // Select rose pulse
	output logic rx_valid_out, // Byte received pulse
	output logic [7:0] rx_byte_out, // Byte received
	output logic tx_req_out // Need next byte pulse
);
	logic cs_q, sclk_q, load_r, fill_r, fresh_r;
	logic [2:0] bit_r;
	logic [7:0] in_r, out_r;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cs_q <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			cs_q <= cs_n_in;
			sclk_q <= sclk_in;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			miso_out <= 1'b0;
			miso_oe_out <= 1'b0;
			frame_start_out <= 1'b0;
			frame_end_out <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_byte_out <= 8'h00;
			tx_req_out <= 1'b0;
			load_r <= 1'b0;
			fresh_r <= 1'b0;
			bit_r <= 3'h0;
			in_r <= 8'h00;
			out_r <= 8'h00;
			fill_r <= 1'b0;
		end else begin
			frame_start_out <= 1'b0;
			rx_valid_out <= 1'b0;
			tx_req_out <= 1'b0;
			frame_end_out <= enable_in & cs_n_in & ~cs_q;
			// Answer to tx_req lands a clock later, so load after that
			fill_r <= load_r;
			if (!enable_in || cs_n_in) begin
				miso_oe_out <= 1'b0;
				bit_r <= 3'h0;
				load_r <= 1'b0;
				fresh_r <= 1'b0;
				fill_r <= 1'b0;
			end else if (cs_q) begin
				miso_oe_out <= 1'b1;
				frame_start_out <= 1'b1;
				tx_req_out <= 1'b1;
				load_r <= 1'b1;
				bit_r <= 3'h0;
			end else begin
				load_r <= 1'b0;
				if (fill_r) begin
					out_r <= tx_byte_in;
					miso_out <= tx_byte_in[7];
				end else if (!sclk_in && sclk_q) begin
					// First fall after a byte boundary keeps the fresh bit 7
					if (fresh_r) begin
						fresh_r <= 1'b0;
					end else begin
						out_r <= {out_r[6:0], 1'b0};
						miso_out <= out_r[6];
					end
				end
				if (sclk_in && !sclk_q) begin
					in_r <= {in_r[6:0], mosi_in};
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						rx_valid_out <= 1'b1;
						rx_byte_out <= {in_r[6:0], mosi_in};
						tx_req_out <= 1'b1;
						load_r <= 1'b1;
						fresh_r <= 1'b1;
					end
				end
			end
		end
	end
endmodule : scs_spi
`default_nettype wire

// file: core/scs_top.sv
// Status byte, command interpreter and configuration store of the signal conditioner
//
// What this block does
// - B0 picks first config, B1 the second
// - Status bit 1 shows active config
// - Busy set while last command still runs
// - Cyclic mode keeps busy asserted throughout
// - Memory error shows signature check result
// - Saturation bit follows arithmetic overflow
// - Status shows command mode and test mode
// - Acknowledge only the stored I2C address
// - Interface setup comes from word 02
// - Interrupt thresholds come from words 13-15
// - Decode frames of selected serial interface
// - Selection holds until reset; default first
// - Cyclic busy stays until halt command BF
// - Busy flag sits in status bit 5
`timescale 1ns/10ps
`default_nettype none
module scs_top import scs_pkg::*; (
	input wire logic clock_in, // 50 MHz system clock
	input wire logic rstn_in, // Power-on reset, active low, clears store
	input wire logic restart_in, // Soft reset pulse, keeps store
	input wire logic test_mode_in, // Factory test mode level
	input wire logic meas_done_in, // Datapath result ready pulse
	input wire logic [23:0] meas_result_in, // Datapath result
	input wire logic alu_saturate_in, // Datapath overflow pulse
	input wire logic i2c_scl_in, // I2C clock level
	input wire logic i2c_sda_in, // I2C data level
	output logic i2c_sda_out, // I2C data drive value
	output logic i2c_sda_oe_out, // I2C data pull low
	input wire logic spi_cs_n_in, // SPI select, active low
	input wire logic spi_sclk_in, // SPI clock
	input wire logic spi_mosi_in, // SPI data in
	output logic spi_miso_out, // SPI data out
	output logic spi_miso_oe_out, // SPI data drive
	output logic meas_start_out, // Start measurement pulse
	output logic meas_cyclic_out, // Cyclic mode level
	output logic sensor_cfg_sel_out, // Active config, 1 = second
	output logic [15:0] sensor_cfg_word_out, // Active config word
	output logic [15:0] if_setup_out, // Interface setup word
	output logic [15:0] irq_thr_a_out, // Threshold word a
	output logic [15:0] irq_thr_b_out, // Threshold word b
	output logic [15:0] irq_thr_c_out, // Threshold word c
	output logic [7:0] status_out // Current status byte
);
	logic [15:0] store_r [STORE_WORDS];
	scs_state_t state_r;
	logic cfg_sel_r, cmd_mode_r, mem_err_r, sat_r;
	logic [5:0] chk_idx_r;
	logic [15:0] chk_sum_r, chk_sum_nxt;
	logic [7:0] cmd_r, tx_byte_r, status_nxt;
	logic have_cmd_r;
	logic [1:0] rx_cnt_r;
	logic [15:0] data_r;
	logic [23:0] resp_r;
	logic [2:0] tx_idx_r, tx_pos;

	logic use_spi;
	logic i_start, i_end, i_rxv, i_txr;
	logic s_start, s_end, s_rxv, s_txr;
	logic [7:0] i_rxb, s_rxb, rx_byte;
	logic frame_start, frame_end, rx_valid, tx_req;

	// Interface type follows the stored setup word
	assign use_spi = if_setup_out[IF_TYPE_BIT];

	scs_i2c u_i2c (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.enable_in(~use_spi),
		.addr_in(if_setup_out[I2C_ADR_MSB:I2C_ADR_LSB]),
		.tx_byte_in(tx_byte_r),
		.scl_in(i2c_scl_in),
		.sda_in(i2c_sda_in),
		.sda_out(i2c_sda_out),
		.sda_oe_out(i2c_sda_oe_out),
		.frame_start_out(i_start),
		.frame_end_out(i_end),
		.rx_valid_out(i_rxv),
		.rx_byte_out(i_rxb),
		.tx_req_out(i_txr)
	);

	scs_spi u_spi (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.enable_in(use_spi),
		.tx_byte_in(tx_byte_r),
		.cs_n_in(spi_cs_n_in),
		.sclk_in(spi_sclk_in),
		.mosi_in(spi_mosi_in),
		.miso_out(spi_miso_out),
		.miso_oe_out(spi_miso_oe_out),
		.frame_start_out(s_start),
		.frame_end_out(s_end),
		.rx_valid_out(s_rxv),
		.rx_byte_out(s_rxb),
		.tx_req_out(s_txr)
	);

	// Disabled engine stays silent, so a plain merge is safe
	assign frame_start = i_start | s_start;
	assign frame_end = i_end | s_end;
	assign rx_valid = i_rxv | s_rxv;
	assign tx_req = i_txr | s_txr;
	assign rx_byte = use_spi ? s_rxb : i_rxb;

	logic exec, idle, running;
	logic do_meas, do_cyc, do_halt, do_wr, do_rd, do_sel1, do_sel2;
	assign exec = frame_end & have_cmd_r;
	assign idle = (state_r == SCS_IDLE);
	assign running = (state_r == SCS_MEAS) || (state_r == SCS_CYCLIC);
	assign do_meas = exec & idle & is_measure(cmd_r);
	assign do_cyc = exec & idle & (cmd_r == CMD_CYCLIC);
	assign do_halt = exec & running & (cmd_r == CMD_HALT_REPEAT);
	assign do_wr = exec & idle & cmd_mode_r & is_store_wr(cmd_r) & (rx_cnt_r == WR_BYTES);
	assign do_rd = exec & idle & is_store_rd(cmd_r);
	assign do_sel1 = exec & idle & (cmd_r == CMD_CFG_FIRST);
	assign do_sel2 = exec & idle & (cmd_r == CMD_CFG_SECOND);

	// Commands run at frame end; extra data bytes keep the last two
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cmd_r <= 8'h00;
			have_cmd_r <= 1'b0;
			rx_cnt_r <= 2'h0;
			data_r <= 16'h0000;
		end else if (frame_start) begin
			have_cmd_r <= 1'b0;
			rx_cnt_r <= 2'h0;
		end else if (rx_valid) begin
			if (rx_cnt_r == 2'h0) begin
				cmd_r <= rx_byte;
				have_cmd_r <= (rx_byte != CMD_SPI_READ);
			end else begin
				data_r <= {data_r[7:0], rx_byte};
			end
			if (rx_cnt_r != WR_BYTES)
				rx_cnt_r <= rx_cnt_r + 2'h1;
		end else if (exec) begin
			have_cmd_r <= 1'b0;
		end
	end

	// Store survives soft restart; only power-on clears it
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < STORE_WORDS; i++)
				store_r[i] <= STORE_RESET;
		end else if (do_wr) begin
			store_r[cmd_r[5:0]] <= data_r;
		end
	end

	assign chk_sum_nxt = chk_sum_r + store_r[chk_idx_r];

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= SCS_CHECK;
			chk_idx_r <= CHK_FIRST;
			chk_sum_r <= SIG_SEED;
			mem_err_r <= 1'b1;
		end else if (restart_in) begin
			state_r <= SCS_CHECK;
			chk_idx_r <= CHK_FIRST;
			chk_sum_r <= SIG_SEED;
		end else begin
			unique case (state_r)
				SCS_CHECK: begin
					chk_sum_r <= chk_sum_nxt;
					chk_idx_r <= chk_idx_r + 6'h01;
					if (chk_idx_r == CHK_LAST) begin
						mem_err_r <= (chk_sum_nxt != store_r[ADR_SIGNATURE]);
						state_r <= SCS_IDLE;
					end
				end
				SCS_IDLE: begin
					if (do_cyc)
						state_r <= SCS_CYCLIC;
					else if (do_meas)
						state_r <= SCS_MEAS;
				end
				SCS_MEAS: begin
					if (do_halt || meas_done_in)
						state_r <= SCS_IDLE;
				end
				SCS_CYCLIC: begin
					if (do_halt)
						state_r <= SCS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			cfg_sel_r <= 1'b0;
		else if (restart_in)
			cfg_sel_r <= 1'b0;
		else if (do_sel1)
			cfg_sel_r <= 1'b0;
		else if (do_sel2)
			cfg_sel_r <= 1'b1;
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			cmd_mode_r <= 1'b0;
		else if (restart_in)
			cmd_mode_r <= 1'b0;
		else if (exec && idle && cmd_r == CMD_START_CM)
			cmd_mode_r <= 1'b1;
		else if (exec && idle && cmd_r == CMD_START_NM)
			cmd_mode_r <= 1'b0;
	end

	// A new overflow wins over the clear from a fresh start
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			sat_r <= 1'b0;
		else if (alu_saturate_in)
			sat_r <= 1'b1;
		else if (do_meas || do_cyc || restart_in)
			sat_r <= 1'b0;
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			resp_r <= 24'h000000;
		else if (do_rd)
			resp_r <= {store_r[cmd_r[5:0]], 8'h00};
		else if (meas_done_in && running)
			resp_r <= meas_result_in;
	end

	always_comb begin
		status_nxt = 8'h00;
		status_nxt[ST_POWER] = 1'b1;
		status_nxt[ST_BUSY] = (state_r != SCS_IDLE) || exec;
		status_nxt[ST_TEST] = test_mode_in;
		status_nxt[ST_CMD] = cmd_mode_r;
		status_nxt[ST_MEMERR] = mem_err_r;
		status_nxt[ST_CFG] = cfg_sel_r;
		status_nxt[ST_SAT] = sat_r;
		status_nxt[ST_SPARE] = 1'b0;
	end

	// Byte request can coincide with frame start on SPI
	assign tx_pos = frame_start ? 3'h0 : tx_idx_r;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_idx_r <= 3'h0;
			tx_byte_r <= 8'h00;
		end else if (tx_req) begin
			unique case (tx_pos)
				3'h0: tx_byte_r <= status_out;
				3'h1: tx_byte_r <= resp_r[23:16];
				3'h2: tx_byte_r <= resp_r[15:8];
				3'h3: tx_byte_r <= resp_r[7:0];
				default: tx_byte_r <= 8'h00;
			endcase
			if (tx_pos != 3'h4)
				tx_idx_r <= tx_pos + 3'h1;
		end else if (frame_start) begin
			tx_idx_r <= 3'h0;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_out <= 8'h00;
			meas_start_out <= 1'b0;
			meas_cyclic_out <= 1'b0;
			sensor_cfg_sel_out <= 1'b0;
			sensor_cfg_word_out <= STORE_RESET;
			if_setup_out <= STORE_RESET;
			irq_thr_a_out <= STORE_RESET;
			irq_thr_b_out <= STORE_RESET;
			irq_thr_c_out <= STORE_RESET;
		end else begin
			status_out <= status_nxt;
			meas_start_out <= do_meas | do_cyc;
			meas_cyclic_out <= ((state_r == SCS_CYCLIC) & ~do_halt) | do_cyc;
			sensor_cfg_sel_out <= cfg_sel_r;
			sensor_cfg_word_out <= cfg_sel_r ? store_r[ADR_CFG_SECOND] : store_r[ADR_CFG_FIRST];
			if_setup_out <= store_r[ADR_IF_SETUP];
			irq_thr_a_out <= store_r[ADR_THR_A];
			irq_thr_b_out <= store_r[ADR_THR_B];
			irq_thr_c_out <= store_r[ADR_THR_C];
		end
	end
endmodule : scs_top
`default_nettype wire

// file: verification/scs_host_model.sv
// I2C host controller model for the status and configuration select block
`timescale 1ns/10ps
`default_nettype none
module scs_host_model (
	input wire logic clock_in, // System clock
	input wire logic dut_oe_in, // Device pulls data low
	output logic scl_out, // Bus clock
	output logic sda_out // Resolved data level
);
	logic low_r = 1'b0;
	initial scl_out = 1'b1;
	// Pull-up wins unless a party pulls low
	assign sda_out = !(low_r || dut_oe_in);
	// Each phase lasts six system clocks, above the three-clock minimum
	task automatic hold(input logic s, input logic l);
		@(posedge clock_in);
		scl_out <= s;
		low_r <= l;
		repeat (5) @(posedge clock_in);
	endtask : hold
	task automatic start();
		hold(1'b1, 1'b0);
		hold(1'b1, 1'b1);
	endtask : start
	task automatic stop();
		hold(1'b0, low_r);
		hold(1'b0, 1'b1);
		hold(1'b1, 1'b1);
		hold(1'b1, 1'b0);
	endtask : stop
	// Data moves only while the clock is low; MSB first, ninth bit is acknowledge
	task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			hold(1'b0, low_r);
			hold(1'b0, !d[i]);
			hold(1'b1, !d[i]);
			#1 q[i] = sda_out;
		end
	endtask : xbyte
endmodule : scs_host_model
`default_nettype wire

// file: verification/scs_top_chk.sv
// Assertion checker for the status and configuration select block
`timescale 1ns/10ps
`default_nettype none
module scs_top_chk import scs_pkg::*; (
	input wire logic clock_in, // Clock
	input wire logic rstn_in, // Reset, active low
	input wire logic restart_in, // Soft reset
	input wire logic test_mode_in, // Test level
	input wire logic meas_done_in, // Result ready
	input wire logic alu_saturate_in, // Overflow
	input wire logic i2c_sda_out, // Data value
	input wire logic i2c_sda_oe_out, // Data pull
	input wire logic spi_miso_oe_out, // SPI drive
	input wire logic meas_start_out, // Start pulse
	input wire logic meas_cyclic_out, // Cyclic level
	input wire logic sensor_cfg_sel_out, // Active config
	input wire logic [15:0] if_setup_out, // Setup word
	input wire logic [7:0] status_out // Status byte
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	// Done ends busy only in a single measurement, so guard on busy and cyclic
	sequence meas_over;
		meas_done_in && !meas_cyclic_out && status_out[ST_BUSY] ##1 !meas_done_in;
	endsequence
	busy_in_cyclic_a: assert property (meas_cyclic_out && $past(meas_cyclic_out) |-> status_out[ST_BUSY])
		else $error("busy low in cyclic mode");
	cfg_bit_a: assert property ($stable(sensor_cfg_sel_out) |-> status_out[ST_CFG] == sensor_cfg_sel_out)
		else $error("status config bit differs from selection");
	test_bit_a: assert property ($stable(test_mode_in) |-> status_out[ST_TEST] == test_mode_in)
		else $error("status test bit wrong");
	start_busy_a: assert property (meas_start_out |-> ##[0:2] status_out[ST_BUSY])
		else $error("measure start without busy");
	done_idle_a: assert property (meas_over |-> ##[1:3] !status_out[ST_BUSY])
		else $error("busy stuck after result");
	halt_idle_a: assert property ($fell(meas_cyclic_out) |-> ##[1:3] !status_out[ST_BUSY])
		else $error("busy stuck after cyclic stop");
	memerr_boot_a: assert property ($rose(rstn_in) |-> ##[0:3] status_out[ST_MEMERR] && status_out[ST_BUSY])
		else $error("no busy and memory error during check");
	spi_quiet_a: assert property (!$past(if_setup_out[IF_TYPE_BIT]) |-> !spi_miso_oe_out)
		else $error("SPI output driven while I2C selected");
	sda_pull_a: assert property (i2c_sda_oe_out |-> !i2c_sda_out && !if_setup_out[IF_TYPE_BIT])
		else $error("I2C data driven high or in SPI mode");
	sat_set_a: assert property (alu_saturate_in |-> ##[1:3] status_out[ST_SAT])
		else $error("saturation not reported");
	cfg_restart_a: assert property (restart_in |-> ##[1:3] !sensor_cfg_sel_out)
		else $error("config selection kept over reset");
endmodule : scs_top_chk
bind scs_top scs_top_chk chk (.clock_in(clock_in), .rstn_in(rstn_in), .restart_in(restart_in),
	.test_mode_in(test_mode_in), .meas_done_in(meas_done_in), .alu_saturate_in(alu_saturate_in),
	.i2c_sda_out(i2c_sda_out), .i2c_sda_oe_out(i2c_sda_oe_out), .spi_miso_oe_out(spi_miso_oe_out),
	.meas_start_out(meas_start_out), .meas_cyclic_out(meas_cyclic_out),
	.sensor_cfg_sel_out(sensor_cfg_sel_out), .if_setup_out(if_setup_out), .status_out(status_out));
`default_nettype wire

// file: verification/scs_tb_top.sv
// Self-checking bench for the status and configuration select block
`timescale 1ns/10ps
`default_nettype none
module scs_tb_top import scs_pkg::*;;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic restart_in = 1'b0;
	logic test_mode_in = 1'b0;
	logic meas_done_in = 1'b0;
	logic [23:0] meas_result_in = 24'h000000;
	logic alu_saturate_in = 1'b0;
	logic scl, sda, sda_oe, cyc, sel;
	logic cs_n = 1'b1, sclk = 1'b0, mosi = 1'b0, miso;
	logic [15:0] cfg_word, if_setup;
	logic [15:0] thr [3];
	logic [7:0] status_out, s;
	logic [23:0] r;
	logic [6:0] adr = 7'h00;
	logic [6:0] found;
	logic [15:0] sig = SIG_SEED;
	int n_errors = 0;
	int check_count = 0;
	always #10 clock_in = !clock_in;
	scs_top dut (.clock_in(clock_in), .rstn_in(rstn_in), .restart_in(restart_in), .test_mode_in(test_mode_in),
		.meas_done_in(meas_done_in), .meas_result_in(meas_result_in), .alu_saturate_in(alu_saturate_in),
		.i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_sda_out(), .i2c_sda_oe_out(sda_oe), .spi_cs_n_in(cs_n),
		.spi_sclk_in(sclk), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(), .meas_start_out(),
		.meas_cyclic_out(cyc), .sensor_cfg_sel_out(sel), .sensor_cfg_word_out(cfg_word),
		.if_setup_out(if_setup), .irq_thr_a_out(thr[0]), .irq_thr_b_out(thr[1]), .irq_thr_c_out(thr[2]),
		.status_out(status_out));
	scs_host_model host (.clock_in(clock_in), .dut_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
	task automatic print_verdict();
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic settle();
		repeat (3) @(posedge clock_in);
		#1;
	endtask : settle
	task automatic wait_idle();
		int k;
		k = 0;
		while (status_out[ST_BUSY] !== 1'b0 && k < 500) begin
			@(posedge clock_in);
			#1 k++;
		end
		if (k == 500) begin
			n_errors++;
			print_verdict();
		end
	endtask : wait_idle
	// Store writes carry two data bytes and feed the running signature
	task automatic frame(input logic [7:0] c, input logic [15:0] d);
		logic [8:0] q;
		host.start();
		host.xbyte({adr, 2'b01}, q);
		check(32'(q[0]), 32'h0);
		host.xbyte({c, 1'b1}, q);
		if (c[7:6] == 2'b01) begin
			host.xbyte({d[15:8], 1'b1}, q);
			host.xbyte({d[7:0], 1'b1}, q);
			sig += d;
		end
		host.stop();
		settle();
	endtask : frame
	task automatic rd(output logic [7:0] st, output logic [23:0] rs);
		logic [8:0] q;
		logic [31:0] all;
		host.start();
		host.xbyte({adr, 2'b11}, q);
		for (int i = 0; i < 4; i++) begin
			host.xbyte({8'hFF, i == 3}, q);
			all = {all[23:0], q[8:1]};
		end
		host.stop();
		st = all[31:24];
		rs = all[23:0];
	endtask : rd
	// Probe upward and keep the first address that answers
	task automatic scan(output logic [6:0] f);
		logic [8:0] q;
		f = 7'h00;
		for (int a = 0; a < 128; a++) begin
			host.start();
			host.xbyte({a[6:0], 2'b11}, q);
			if (!q[0]) begin
				host.xbyte(9'h1FF, q);
				host.stop();
				check(32'(q[8:1]), 32'h4E);
				f = a[6:0];
				break;
			end
			host.stop();
		end
	endtask : scan
	// Mode 0 frame: command byte goes out while the status byte comes back
	task automatic spi_xfer(input logic [7:0] c, output logic [7:0] b);
		@(posedge clock_in);
		cs_n <= 1'b0;
		repeat (3) @(posedge clock_in);
		for (int i = 7; i >= 0; i--) begin
			mosi <= c[i];
			repeat (3) @(posedge clock_in);
			sclk <= 1'b1;
			repeat (3) @(posedge clock_in);
			b[i] = miso;
			sclk <= 1'b0;
		end
		repeat (3) @(posedge clock_in);
		cs_n <= 1'b1;
	endtask : spi_xfer
	initial begin
		repeat (2) @(posedge clock_in);
		rstn_in <= 1'b1;
		@(posedge clock_in);
		@(posedge clock_in);
		#1 check(32'(status_out), 32'h64);
		wait_idle();
		check(32'(status_out), 32'h44);
		rd(s, r);
		check(32'(s), 32'h44);
		frame(CMD_START_CM, 16'h0000);
		check(32'(status_out), 32'h4C);
		@(posedge clock_in);
		test_mode_in <= 1'b1;
		settle();
		check(32'(status_out), 32'h5C);
		@(posedge clock_in);
		test_mode_in <= 1'b0;
		frame({2'b01, ADR_CFG_FIRST}, 16'h1111);
		frame({2'b01, ADR_CFG_SECOND}, 16'h2222);
		for (int i = 0; i < 3; i++) begin
			frame(8'({2'b01, ADR_THR_A} + i), 16'hA000 + 16'(i));
			check(32'(thr[i]), 32'hA000 + i);
		end
		check(32'({sel, cfg_word}), 32'h01111);
		frame(CMD_CFG_SECOND, 16'h0000);
		check(32'({sel, status_out[ST_CFG], cfg_word}), 32'h32222);
		frame(CMD_CFG_FIRST, 16'h0000);
		check(32'({sel, status_out[ST_CFG], cfg_word}), 32'h01111);
		frame(CMD_CFG_SECOND, 16'h0000);
		frame({2'b01, ADR_IF_SETUP}, 16'h0042);
		check(32'(if_setup), 32'h0042);
		scan(found);
		check(32'(found), 32'h21);
		adr = found;
		frame({2'b01, ADR_SIGNATURE}, sig);
		@(posedge clock_in);
		restart_in <= 1'b1;
		@(posedge clock_in);
		restart_in <= 1'b0;
		settle();
		wait_idle();
		check(32'(status_out), 32'h40);
		frame(CMD_MEASURE, 16'h0000);
		check(32'(status_out[ST_BUSY]), 32'h1);
		@(posedge clock_in);
		meas_done_in <= 1'b1;
		meas_result_in <= 24'h123456;
		alu_saturate_in <= 1'b1;
		@(posedge clock_in);
		meas_done_in <= 1'b0;
		alu_saturate_in <= 1'b0;
		settle();
		check(32'(status_out), 32'h41);
		rd(s, r);
		check(32'({s, r}), 32'h41123456);
		frame(CMD_CYCLIC, 16'h0000);
		frame(CMD_CFG_SECOND, 16'h0000);
		rd(s, r);
		check(32'({s[ST_BUSY], sel, cyc}), 32'h5);
		frame(CMD_HALT_REPEAT, 16'h0000);
		check(32'({status_out[ST_BUSY], cyc}), 32'h0);
		frame(CMD_START_CM, 16'h0000);
		frame({2'b01, ADR_IF_SETUP}, 16'h0043);
		check(32'(if_setup), 32'h0043);
		spi_xfer(CMD_SPI_READ, s);
		check(32'(s), 32'h48);
		print_verdict();
	end
endmodule : scs_tb_top
`default_nettype wire
